// File: ccd_consts.vh
// Purpose: Shared constants of the clear/complement/decrement/call unit
// Assumes: Included by bare name from every design file of the unit
// Notes:   Byte addresses on the APB side, one aligned word per register
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH

// Register byte offsets
`define CCD_OFS_INSTR     12'h000
`define CCD_OFS_ACC       12'h004
`define CCD_OFS_LATCH     12'h008
`define CCD_OFS_PC        12'h00C
`define CCD_OFS_STATUS    12'h010
`define CCD_OFS_FADDR     12'h014
`define CCD_OFS_FDATA     12'h018
`define CCD_OFS_WDOG      12'h01C
`define CCD_OFS_STACK     12'h020

// Instruction word fields
`define CCD_OP_MSB        3
`define CCD_OP_LSB        0
`define CCD_DEST_BIT      7
`define CCD_FADR_MSB      14
`define CCD_FADR_LSB      8

// Opcodes
`define CCD_OP_NOP        4'h0
`define CCD_OP_WDCLR      4'h1
`define CCD_OP_CALLACC    4'h2
`define CCD_OP_COMPL      4'h3
`define CCD_OP_CLRREG     4'h4
`define CCD_OP_CLRACC     4'h5
`define CCD_OP_DECREG     4'h6
`define CCD_OP_DECSKIP    4'h7

// Status register bit positions
`define CCD_ST_ZERO       0
`define CCD_ST_TIMEOUTN   1
`define CCD_ST_PWRDOWNN   2
`define CCD_ST_SKIP       3
`define CCD_ST_BUSY       4

// Reset, clear and counter top values
`define CCD_RST_BYTE      8'h00
`define CCD_RST_PC        15'h0000
`define CCD_RST_FLAG_N    1'b1
`define CCD_WDOG_CLEAR    8'h00
`define CCD_PRESC_CLEAR   8'h00
`define CCD_PRESC_TOP     8'hFF
`define CCD_WDOG_TOP      8'hFF

`endif

// File: ccd_alu.v
// Purpose: Result and zero detect for the byte-wide operations
// Assumes: Opcode and operand stable for the execute cycle
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "ccd_consts.vh"

module ccd_alu
(
   input  wire [3:0] op,
   input  wire [7:0] operand,
   output reg  [7:0] result,
   output wire       zero
);

   // Select the byte result for each opcode
   always @*
   begin
      case (op)
         `CCD_OP_COMPL   : result = ~operand;
         `CCD_OP_CLRREG  : result = `CCD_RST_BYTE;
         `CCD_OP_CLRACC  : result = `CCD_RST_BYTE;
         `CCD_OP_DECREG  : result = operand - 8'h01;
         `CCD_OP_DECSKIP : result = operand - 8'h01;
         default         : result = operand;
      endcase
   end

   // Zero when the stored byte is all zero
   assign zero = (result == 8'h00);

endmodule // ccd_alu

// File: ccd_return_stack.v
// Purpose: Sixteen-level circular return address stack
// Assumes: Push is a one-cycle pulse
// Notes:   Overflow wraps and overwrites the oldest entry
`timescale 1ns/1ps
`include "ccd_consts.vh"

module ccd_return_stack
(
   input  wire        mclk,
   input  wire        arst_n,
   input  wire        push,
   input  wire [14:0] pushData,
   output wire [14:0] top,
   output reg  [3:0]  ptr
);

   reg [14:0] entry [0:15];

   // Entries need no reset; only the pointer is control state
   always @(posedge mclk)
   begin
      if (push)
         entry[ptr] <= pushData;
   end

   // Pointer advances on each push
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         ptr <= 4'h0;
      else if (push)
         ptr <= ptr + 4'h1;
   end

   assign top = entry[ptr - 4'h1];

endmodule // ccd_return_stack

// File: ccd_exec_unit.v
// Purpose: Executes the watchdog-clear, call-via-accumulator, complement,
//          clear, decrement and decrement-skip instructions
// Assumes: APB master; one instruction cycle per mclk
// Notes:   Writing the instruction register issues one instruction
//
// Overview of operation
// - Watchdog clear zeroes counter, sets both flags
// - Watchdog clear also zeroes the prescaler
// - Call pushes PC plus one onto stack
// - Call loads PC from latch and accumulator
// - Call takes two cycles, flags untouched
// - Complement register, route by destination, zero
// - Clear register writes zero, sets zero
// - Clear accumulator writes zero, sets zero
// - Decrement register, route by destination, zero
// - Decrement-skip routes result, flags untouched
// - Zero decrement-skip result turns next instruction into no-op
`timescale 1ns/1ps
`include "ccd_consts.vh"

module ccd_exec_unit
(
   input  wire        mclk,
   input  wire        arst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr
);

   // One-hot execution states
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_EXEC  = 3'b010;
   localparam [2:0] ST_CALL2 = 3'b100;

   reg  [2:0]  state;
   reg  [15:0] instr;
   reg  [7:0]  acc;
   reg  [6:0]  upperAddrLatch;
   reg  [14:0] pc;
   reg         zeroFlag;
   reg         timeoutFlagN;
   reg         powerdownFlagN;
   reg         skipPending;
   reg  [6:0]  fileAddr;
   reg  [7:0]  watchdogCounter;
   reg  [7:0]  prescaler;
   reg         readyQ;
   reg  [7:0]  fileMem [0:127];

   reg  [31:0] next_prdata;
   reg         next_slverr;

   wire        busy;
   wire        access;
   wire        done;
   wire        doWrite;
   wire [3:0]  opcode;
   wire        dest;
   wire [6:0]  opAddr;
   wire [7:0]  opValue;
   wire [7:0]  aluResult;
   wire        aluZero;
   wire        execLive;
   wire        pushCall;
   wire [14:0] pcPlusOne;
   wire [14:0] stackTop;
   wire [3:0]  stackPtr;
   wire        prescTick;
   wire        storeToReg;
   wire        storeToAcc;

   // Decoded instruction fields
   assign opcode  = instr[`CCD_OP_MSB:`CCD_OP_LSB];
   assign dest    = instr[`CCD_DEST_BIT];
   assign opAddr  = instr[`CCD_FADR_MSB:`CCD_FADR_LSB];
   assign opValue = fileMem[opAddr];

   // Bus handshake terms; the bus waits while an instruction runs
   assign busy    = (state != ST_IDLE);
   assign access  = psel & penable;
   assign pready  = readyQ;
   assign done    = access & readyQ;
   assign doWrite = done & pwrite & ~next_slverr;

   // An instruction following a zero decrement-skip is a no-op
   assign execLive = (state == ST_EXEC) & ~skipPending;

   assign pcPlusOne = pc + 15'h0001;
   assign pushCall  = execLive & (opcode == `CCD_OP_CALLACC);

   // Destination routing for byte results
   assign storeToReg = execLive & (
      (opcode == `CCD_OP_CLRREG) |
      (dest & ((opcode == `CCD_OP_COMPL) |
               (opcode == `CCD_OP_DECREG) |
               (opcode == `CCD_OP_DECSKIP))));
   assign storeToAcc = execLive & (
      (opcode == `CCD_OP_CLRACC) |
      (~dest & ((opcode == `CCD_OP_COMPL) |
                (opcode == `CCD_OP_DECREG) |
                (opcode == `CCD_OP_DECSKIP))));

   // Prescaler wraps to give the watchdog its count enable
   assign prescTick = (prescaler == `CCD_PRESC_TOP);

   ccd_alu u_alu
   (
      .op      (opcode),
      .operand (opValue),
      .result  (aluResult),
      .zero    (aluZero)
   );

   ccd_return_stack u_stack
   (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .push     (pushCall),
      .pushData (pcPlusOne),
      .top      (stackTop),
      .ptr      (stackPtr)
   );

   // Read data and error for the addressed register
   always @*
   begin
      next_prdata = 32'h00000000;
      next_slverr = 1'b0;
      case (paddr)
         `CCD_OFS_INSTR  : next_prdata = {16'h0000, instr};
         `CCD_OFS_ACC    : next_prdata = {24'h000000, acc};
         `CCD_OFS_LATCH  : next_prdata = {25'h0000000, upperAddrLatch};
         `CCD_OFS_PC     : next_prdata = {17'h00000, pc};
         `CCD_OFS_STATUS :
         begin
            next_prdata[`CCD_ST_ZERO]     = zeroFlag;
            next_prdata[`CCD_ST_TIMEOUTN] = timeoutFlagN;
            next_prdata[`CCD_ST_PWRDOWNN] = powerdownFlagN;
            next_prdata[`CCD_ST_SKIP]     = skipPending;
            next_prdata[`CCD_ST_BUSY]     = busy;
         end
         `CCD_OFS_FADDR  : next_prdata = {25'h0000000, fileAddr};
         `CCD_OFS_FDATA  : next_prdata = {24'h000000, fileMem[fileAddr]};
         `CCD_OFS_WDOG   : next_prdata = {16'h0000, prescaler,
                                          watchdogCounter};
         `CCD_OFS_STACK  : next_prdata = {13'h0000, stackPtr, stackTop};
         default         : next_slverr = 1'b1;
      endcase
   end

   // Answer one cycle into the access phase, only when idle
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         readyQ  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (done)
      begin
         readyQ  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (access && !busy)
      begin
         readyQ  <= 1'b1;
         prdata  <= pwrite ? 32'h00000000 : next_prdata;
         pslverr <= next_slverr;
      end
   end

   // Execution sequence: issue, execute, optional second call cycle
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE :
               if (doWrite && paddr == `CCD_OFS_INSTR)
                  state <= ST_EXEC;
            ST_EXEC :
               if (pushCall)
                  state <= ST_CALL2;
               else
                  state <= ST_IDLE;
            ST_CALL2 :
               state <= ST_IDLE;
            default :
               state <= ST_IDLE;
         endcase
      end
   end

   // File memory: software window and instruction write-back
   always @(posedge mclk)
   begin
      if (storeToReg)
         fileMem[opAddr] <= aluResult;
      else if (doWrite && paddr == `CCD_OFS_FDATA)
         fileMem[fileAddr] <= pwdata[7:0];
   end

   // Instruction and software-visible registers
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         instr          <= 16'h0000;
         acc            <= `CCD_RST_BYTE;
         upperAddrLatch <= 7'h00;
         pc             <= `CCD_RST_PC;
         fileAddr       <= 7'h00;
      end
      else if (state == ST_EXEC)
      begin
         if (pushCall)
            pc <= {upperAddrLatch, acc};
         else
            pc <= pcPlusOne;
         if (storeToAcc)
            acc <= aluResult;
      end
      else if (doWrite)
      begin
         case (paddr)
            `CCD_OFS_INSTR : instr          <= pwdata[15:0];
            `CCD_OFS_ACC   : acc            <= pwdata[7:0];
            `CCD_OFS_LATCH : upperAddrLatch <= pwdata[6:0];
            `CCD_OFS_PC    : pc             <= pwdata[14:0];
            `CCD_OFS_FADDR : fileAddr       <= pwdata[6:0];
            default        : fileAddr       <= fileAddr;
         endcase
      end
   end

   // Zero flag and skip request; call and decrement-skip leave flags
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         zeroFlag    <= 1'b0;
         skipPending <= 1'b0;
      end
      else if (state == ST_EXEC)
      begin
         if (skipPending)
            skipPending <= 1'b0;
         else
         begin
            case (opcode)
               `CCD_OP_COMPL   : zeroFlag <= aluZero;
               `CCD_OP_DECREG  : zeroFlag <= aluZero;
               `CCD_OP_CLRREG  : zeroFlag <= 1'b1;
               `CCD_OP_CLRACC  : zeroFlag <= 1'b1;
               `CCD_OP_DECSKIP : skipPending <= aluZero;
               default         : zeroFlag <= zeroFlag;
            endcase
         end
      end
   end

   // Watchdog prescaler, counter and its active-low flags
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prescaler       <= `CCD_PRESC_CLEAR;
         watchdogCounter <= `CCD_WDOG_CLEAR;
         timeoutFlagN    <= `CCD_RST_FLAG_N;
         powerdownFlagN  <= `CCD_RST_FLAG_N;
      end
      else if (execLive && opcode == `CCD_OP_WDCLR)
      begin
         watchdogCounter <= `CCD_WDOG_CLEAR;
         prescaler       <= `CCD_PRESC_CLEAR;
         timeoutFlagN    <= 1'b1;
         powerdownFlagN  <= 1'b1;
      end
      else
      begin
         prescaler <= prescaler + 8'h01;
         if (prescTick)
         begin
            watchdogCounter <= watchdogCounter + 8'h01;
            if (watchdogCounter == `CCD_WDOG_TOP)
               timeoutFlagN <= 1'b0; // Time-out on counter wrap
         end
      end
   end

endmodule // ccd_exec_unit

// File: ccd_exec_unit_assertions.sv
// Purpose: Port-level checks of the exec unit
// Assumes: Sees only the top ports, one clock domain
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`include "ccd_consts.vh"
module ccd_exec_chk
(
   input wire        mclk,
   input wire        arst_n,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   // Completed transfer and instruction issue
   wire done;
   wire issue;
   assign done  = psel && penable && pready;
   assign issue = done && pwrite && paddr == `CCD_OFS_INSTR;

   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_zero_data: assert property (pslverr |-> pready && prdata == 0)
      else $error("error without ready or data");
   a_unmapped_err: assert property (done && paddr > 12'h020 |-> pslverr)
      else $error("no error on unmapped");
   a_mapped_no_err: assert property
      (done && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped");
   a_access_bounded: assert property
      (psel && penable && !pready |-> ##[1:5] pready)
      else $error("access never answered");
   a_exec_busy: assert property (issue |=> !pready)
      else $error("ready while executing");
   a_call_two_cycles: assert property
      (issue && pwdata[3:0] == `CCD_OP_CALLACC |=> !pready [*2])
      else $error("call shorter than two cycles");
   a_status_upper: assert property
      (done && !pwrite && paddr == `CCD_OFS_STATUS |-> prdata[31:5] == 0)
      else $error("status upper bits set");

   c_call: cover property (issue && pwdata[3:0] == `CCD_OP_CALLACC);
   c_skip: cover property (issue && pwdata[3:0] == `CCD_OP_DECSKIP);
   c_err:  cover property (pslverr);
endmodule // ccd_exec_chk

// File: ccd_exec_unit_bench.sv
// Purpose: Self-checking bench of the exec unit over APB
// Assumes: One instruction per INSTR write
// Notes:   Watchdog wrap needs about 65536 cycles
`timescale 1ns/1ps
`include "ccd_consts.vh"
module ccd_exec_unit_bench;
   reg         mclk;
   reg         arst_n;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   integer     err_count;
   integer     total_checks;
   reg  [31:0] rdat;
   reg         rerr;

   ccd_exec_unit uut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Clock
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task summarize;
   begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   task cmp(input [63:0] nm, input [31:0] e, input [31:0] g);
   begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
         err_count = err_count + 1;
         $display("BAD %0s exp %h got %h", nm, e, g);
      end
   end
   endtask

   // One APB transfer; pready is sampled at rising edges under a bound,
   // data taken and the request released at the completing edge only
   task xfer(input w, input [11:0] a, input [31:0] d);
      integer n;
   begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n = n + 1;
         @(posedge mclk);
      end
      if (pready !== 1'b1)
      begin
         err_count = err_count + 1;
         $display("BAD pready exp 1 got %b", pready);
         summarize;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   task rc(input [11:0] a, input [31:0] m, input [31:0] e, input [63:0] nm);
   begin
      xfer(1'b0, a, 32'h0);
      cmp(nm, e, rdat & m);
   end
   endtask

   task ex(input [3:0] op, input d);
   begin
      xfer(1'b1, `CCD_OFS_INSTR, {17'h0, 7'h7F, d, 3'h0, op});
   end
   endtask

   task t_reset;
   begin
      rc(`CCD_OFS_STATUS, 32'h1F, 32'h06, "status");
      xfer(1'b0, 12'h024, 32'h0);
      cmp("slverr", 32'h1, {31'h0, rerr});
      xfer(1'b1, `CCD_OFS_FADDR, 32'h7F);
      $display("reset test done");
   end
   endtask

   task t_compl;
   begin
      xfer(1'b1, `CCD_OFS_FDATA, 32'hFF);
      ex(`CCD_OP_COMPL, 1'b1);
      rc(`CCD_OFS_FDATA, 32'hFF, 32'h00, "file");
      rc(`CCD_OFS_STATUS, 32'h1, 32'h1, "zero");
      ex(`CCD_OP_COMPL, 1'b0);
      rc(`CCD_OFS_ACC, 32'hFF, 32'hFF, "acc");
      rc(`CCD_OFS_STATUS, 32'h1, 32'h0, "zero");
      rc(`CCD_OFS_FDATA, 32'hFF, 32'h00, "file");
      $display("complement test done");
   end
   endtask

   task t_clear;
   begin
      xfer(1'b1, `CCD_OFS_FDATA, 32'h5A);
      ex(`CCD_OP_CLRREG, 1'b0);
      rc(`CCD_OFS_FDATA, 32'hFF, 32'h00, "file");
      rc(`CCD_OFS_STATUS, 32'h1, 32'h1, "zero");
      ex(`CCD_OP_COMPL, 1'b0);
      ex(`CCD_OP_CLRACC, 1'b0);
      rc(`CCD_OFS_ACC, 32'hFF, 32'h00, "acc");
      rc(`CCD_OFS_STATUS, 32'h1, 32'h1, "zero");
      $display("clear test done");
   end
   endtask

   task t_dec;
   begin
      xfer(1'b1, `CCD_OFS_FDATA, 32'h01);
      ex(`CCD_OP_DECREG, 1'b0);
      rc(`CCD_OFS_ACC, 32'hFF, 32'h00, "acc");
      rc(`CCD_OFS_FDATA, 32'hFF, 32'h01, "file");
      ex(`CCD_OP_DECREG, 1'b1);
      ex(`CCD_OP_DECREG, 1'b1);
      rc(`CCD_OFS_FDATA, 32'hFF, 32'hFF, "file");
      rc(`CCD_OFS_STATUS, 32'h1, 32'h0, "zero");
      $display("decrement test done");
   end
   endtask

   task t_skip;
   begin
      xfer(1'b1, `CCD_OFS_FDATA, 32'h02);
      xfer(1'b1, `CCD_OFS_PC, 32'h0100);
      ex(`CCD_OP_DECSKIP, 1'b1);
      rc(`CCD_OFS_FDATA, 32'hFF, 32'h01, "file");
      rc(`CCD_OFS_STATUS, 32'h9, 32'h0, "status");
      ex(`CCD_OP_DECSKIP, 1'b1);
      rc(`CCD_OFS_STATUS, 32'h9, 32'h8, "status");
      xfer(1'b1, `CCD_OFS_ACC, 32'h55);
      ex(`CCD_OP_CLRACC, 1'b0);
      rc(`CCD_OFS_ACC, 32'hFF, 32'h55, "acc");
      rc(`CCD_OFS_PC, 32'h7FFF, 32'h0103, "pc");
      rc(`CCD_OFS_STATUS, 32'h8, 32'h0, "skip");
      $display("skip test done");
   end
   endtask

   task t_call;
   begin
      ex(`CCD_OP_CLRACC, 1'b0);
      xfer(1'b1, `CCD_OFS_ACC, 32'h34);
      xfer(1'b1, `CCD_OFS_LATCH, 32'h7F);
      xfer(1'b1, `CCD_OFS_PC, 32'h1234);
      ex(`CCD_OP_CALLACC, 1'b0);
      rc(`CCD_OFS_PC, 32'h7FFF, 32'h7F34, "pc");
      rc(`CCD_OFS_STACK, 32'h7FFFF, 32'h09235, "stack");
      rc(`CCD_OFS_STATUS, 32'h7, 32'h7, "status");
      $display("call test done");
   end
   endtask

   task t_wdog;
   begin
      repeat (66000) @(posedge mclk);
      rc(`CCD_OFS_STATUS, 32'h6, 32'h4, "timeout");
      ex(`CCD_OP_WDCLR, 1'b0);
      rc(`CCD_OFS_WDOG, 32'hFF, 32'h0, "wdog");
      cmp("presc", 32'h1, {31'h0, rdat[15:8] < 8'h10});
      rc(`CCD_OFS_STATUS, 32'h6, 32'h6, "flags");
      $display("watchdog test done");
   end
   endtask

   // Reset, then the scenarios
   initial
   begin
      err_count = 0;
      total_checks = 0;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      t_reset;
      t_compl;
      t_clear;
      t_dec;
      t_skip;
      t_call;
      t_wdog;
      summarize;
   end
endmodule // ccd_exec_unit_bench

bind ccd_exec_unit ccd_exec_chk chk (.mclk(mclk), .arst_n(arst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
